// *** rtl/serializer_gpio_config_bank.v ***
// Pin configuration bank for pins 3 and 5 to 8, behind an AXI4-Lite slave.
// Assumes pin inputs, remote value and link state arrive asynchronously.
// Overview of operation
// - Pin 3 drives value in local output, and in code 111 on loss
// - Mode x00 functional input, x10 high impedance
// - Pin 3 codes 001 output, 011 input
// - Code 101 drives remote value, holds on loss
// - Code 111 drives remote, local value on loss
// - Port select moves pin 3 to second port
// - Pair modes 00 functional, 10 high impedance
// - Pair modes 01 output, 11 input
// - Pair pins drive value in output mode
// - Pin 7/8 register field layout
// - Value bit sets level, resets low
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_map.vh"
module serializer_gpio_config_bank (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire link_up_async,
    input wire remote_pin_three_async,
    input wire pin_three_in,
    input wire second_port_pin_three_in,
    input wire [3:0] pair_pin_in,
    output reg pin_three_out,
    output reg pin_three_oe,
    output reg second_port_pin_three_out,
    output reg second_port_pin_three_oe,
    output reg [3:0] pair_pin_out,
    output reg [3:0] pair_pin_oe,
    output reg [4:0] gp_input_level,
    output reg [4:0] functional_input_active
);
    reg [7:0] pin3_config;
    reg [7:0] pin5_pin6_config;
    reg [7:0] pin7_pin8_config;
    reg [7:0] bank_control;
    reg [7:0] aw_addr;
    reg aw_held;
    reg [7:0] w_data;
    reg w_strobe;
    reg w_held;
    reg [1:0] link_sync;
    reg [1:0] remote_sync;
    reg [1:0] p3_sync;
    reg [1:0] p3b_sync;
    reg [7:0] pair_sync_a;
    reg [3:0] pair_sync_b;
    wire second_port_select;
    wire [4:0] cell_out;
    wire [4:0] cell_oe;
    wire [4:0] cell_gp;
    wire [4:0] cell_fn;
    wire [4:0] pin_level;
    wire [14:0] cell_mode;
    wire [4:0] cell_value;
    wire do_write;
    localparam [1:0] READ_IDLE = 2'b01;
    localparam [1:0] READ_ANSWER = 2'b10;
    reg [1:0] read_state;

    // Byte address is four times the printed index
    function [7:0] word_index;
        input [7:0] byte_addr;
        begin
            word_index = {2'b00, byte_addr[7:2]};
        end
    endfunction

    function [7:0] reg_read;
        input [7:0] index;
        begin
            case (index)
                `PIN3_CONFIG_INDEX: reg_read = pin3_config;
                `PIN5_PIN6_CONFIG_INDEX: reg_read = pin5_pin6_config;
                `PIN7_PIN8_CONFIG_INDEX: reg_read = pin7_pin8_config;
                `BANK_CONTROL_INDEX: reg_read = bank_control;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    function is_mapped;
        input [7:0] index;
        begin
            is_mapped = (index == `PIN3_CONFIG_INDEX) || (index == `PIN5_PIN6_CONFIG_INDEX) ||
                (index == `PIN7_PIN8_CONFIG_INDEX) || (index == `BANK_CONTROL_INDEX);
        end
    endfunction

    // Pair fields hold no remote bit, so the cell sees it as zero
    function [2:0] pair_mode;
        input [7:0] cfg;
        input hi;
        begin
            if (hi) begin
                pair_mode = {1'b0, cfg[`HI_MODE_LSB+1:`HI_MODE_LSB]};
            end else begin
                pair_mode = {1'b0, cfg[`LO_MODE_LSB+1:`LO_MODE_LSB]};
            end
        end
    endfunction

    function pair_value;
        input [7:0] cfg;
        input hi;
        begin
            pair_value = hi ? cfg[`HI_VALUE_BIT] : cfg[`LO_VALUE_BIT];
        end
    endfunction

    // Writable bits per register; reserved bits stay zero
    function [7:0] write_mask;
        input [7:0] index;
        begin
            case (index)
                `PIN3_CONFIG_INDEX: write_mask = `PIN3_WRITE_MASK;
                `PIN5_PIN6_CONFIG_INDEX: write_mask = `PAIR_WRITE_MASK;
                `PIN7_PIN8_CONFIG_INDEX: write_mask = `PAIR_WRITE_MASK;
                `BANK_CONTROL_INDEX: write_mask = `CONTROL_WRITE_MASK;
                default: write_mask = 8'h00;
            endcase
        end
    endfunction

    assign second_port_select = bank_control[0];
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // Write side: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BUS_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_strobe <= 1'b0;
            pin3_config <= `CONFIG_RESET;
            pin5_pin6_config <= `CONFIG_RESET;
            pin7_pin8_config <= `CONFIG_RESET;
            bank_control <= `CONFIG_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= word_index(s_axi_awaddr);
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata[7:0];
                w_strobe <= s_axi_wstrb[0];
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr) ? `BUS_OKAY : `BUS_SLVERR;
                if (w_strobe) begin
                    case (aw_addr)
                        `PIN3_CONFIG_INDEX: pin3_config <= w_data & write_mask(aw_addr);
                        `PIN5_PIN6_CONFIG_INDEX: pin5_pin6_config <= w_data & write_mask(aw_addr);
                        `PIN7_PIN8_CONFIG_INDEX: pin7_pin8_config <= w_data & write_mask(aw_addr);
                        `BANK_CONTROL_INDEX: bank_control <= w_data & write_mask(aw_addr);
                        default: bank_control <= bank_control;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read side: one read outstanding
    // Arready stays low while an answer stands, so read data cannot be overtaken
    always @(posedge aclk) begin
        if (!aresetn) begin
            read_state <= READ_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BUS_OKAY;
        end else begin
            case (read_state)
                READ_IDLE: begin
                    if (s_axi_arvalid) begin
                        read_state <= READ_ANSWER;
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= {24'h000000, reg_read(word_index(s_axi_araddr))};
                        s_axi_rresp <= is_mapped(word_index(s_axi_araddr)) ? `BUS_OKAY : `BUS_SLVERR;
                    end
                end
                READ_ANSWER: begin
                    if (s_axi_rready) begin
                        read_state <= READ_IDLE;
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                    end
                end
                default: begin
                    read_state <= READ_IDLE;
                    s_axi_arready <= 1'b1;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end

    // Asynchronous inputs; first stage feeds only the second
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_sync <= 2'b00;
            remote_sync <= 2'b00;
            p3_sync <= 2'b00;
            p3b_sync <= 2'b00;
            pair_sync_a <= 8'h00;
            pair_sync_b <= 4'h0;
        end else begin
            link_sync <= {link_sync[0], link_up_async};
            remote_sync <= {remote_sync[0], remote_pin_three_async};
            p3_sync <= {p3_sync[0], pin_three_in};
            p3b_sync <= {p3b_sync[0], second_port_pin_three_in};
            pair_sync_a <= {pair_sync_a[3:0], pair_pin_in};
            pair_sync_b <= pair_sync_a[7:4];
        end
    end

    assign cell_mode = {
        pair_mode(pin7_pin8_config, 1'b1),
        pair_mode(pin7_pin8_config, 1'b0),
        pair_mode(pin5_pin6_config, 1'b1),
        pair_mode(pin5_pin6_config, 1'b0),
        pin3_config[2:0]};
    assign cell_value = {pair_value(pin7_pin8_config, 1'b1), pair_value(pin7_pin8_config, 1'b0),
        pair_value(pin5_pin6_config, 1'b1), pair_value(pin5_pin6_config, 1'b0), pin3_config[`LO_VALUE_BIT]};
    assign pin_level = {pair_sync_b, second_port_select ? p3b_sync[1] : p3_sync[1]};

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : cells
            pin_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .mode(cell_mode[3*g+2:3*g]),
                .value(cell_value[g]),
                .remote_capable(g == 0),
                .remote_value(remote_sync[1]),
                .link_up(link_sync[1]),
                .pin_out(cell_out[g]),
                .pin_oe(cell_oe[g]),
                .gp_input(cell_gp[g]),
                .functional_input(cell_fn[g])
            );
        end
    endgenerate

    // Pin 3 control follows the port selection; the idle port floats
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_three_out <= 1'b0;
            pin_three_oe <= 1'b0;
            second_port_pin_three_out <= 1'b0;
            second_port_pin_three_oe <= 1'b0;
            pair_pin_out <= 4'h0;
            pair_pin_oe <= 4'h0;
            gp_input_level <= 5'h00;
            functional_input_active <= 5'h00;
        end else begin
            pin_three_out <= second_port_select ? 1'b0 : cell_out[0];
            pin_three_oe <= second_port_select ? 1'b0 : cell_oe[0];
            second_port_pin_three_out <= second_port_select ? cell_out[0] : 1'b0;
            second_port_pin_three_oe <= second_port_select ? cell_oe[0] : 1'b0;
            pair_pin_out <= cell_out[4:1];
            pair_pin_oe <= cell_oe[4:1];
            gp_input_level <= cell_gp & pin_level;
            functional_input_active <= cell_fn;
        end
    end
endmodule // serializer_gpio_config_bank
`default_nettype wire

// *** shared/gpio_bank_map.vh ***
// Register offsets, field positions and reset values of the pin configuration bank.
// Assumes inclusion by bare name from the design files.
`ifndef GPIO_BANK_MAP_VH
`define GPIO_BANK_MAP_VH
`define PIN3_CONFIG_INDEX 8'h0f
`define PIN5_PIN6_CONFIG_INDEX 8'h10
`define PIN7_PIN8_CONFIG_INDEX 8'h11
`define BANK_CONTROL_INDEX 8'h14
`define CONFIG_RESET 8'h00
`define PIN3_WRITE_MASK 8'h0f
`define PAIR_WRITE_MASK 8'hbb
`define CONTROL_WRITE_MASK 8'h01
`define LO_VALUE_BIT 3
`define HI_VALUE_BIT 7
`define LO_MODE_LSB 0
`define HI_MODE_LSB 4
`define BUS_OKAY 2'b00
`define BUS_SLVERR 2'b10
`endif

// *** rtl/pin_cell.v ***
// One general-purpose pin: decodes a mode field into drive, enable and input use.
// Assumes mode and value come from registers on the same clock; remote inputs already synchronised.
`timescale 1ns/1ps
`default_nettype none
module pin_cell (
    input wire aclk,
    input wire aresetn,
    input wire [2:0] mode,
    input wire value,
    input wire remote_capable,
    input wire remote_value,
    input wire link_up,
    output reg pin_out,
    output reg pin_oe,
    output reg gp_input,
    output reg functional_input
);
    reg held_remote;
    reg next_out;
    reg next_oe;
    wire [2:0] eff_mode;
    // Pairs without remote control only see the low two bits
    assign eff_mode = remote_capable ? mode : {1'b0, mode[1:0]};

    always @(posedge aclk) begin
        if (!aresetn) begin
            held_remote <= 1'b0;
        end else if (link_up) begin
            held_remote <= remote_value;
        end
    end

    always @* begin
        next_out = 1'b0;
        next_oe = 1'b0;
        case (eff_mode)
            3'b001: begin
                next_out = value;
                next_oe = 1'b1;
            end
            3'b101: begin
                next_out = link_up ? remote_value : held_remote;
                next_oe = 1'b1;
            end
            3'b111: begin
                next_out = link_up ? remote_value : value;
                next_oe = 1'b1;
            end
            default: begin
                next_out = 1'b0;
                next_oe = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            gp_input <= 1'b0;
            functional_input <= 1'b0;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            gp_input <= (eff_mode[1:0] == 2'b11) && !eff_mode[2];
            functional_input <= (eff_mode[1:0] == 2'b00);
        end
    end
endmodule // pin_cell
`default_nettype wire

// *** sim/remote_deserializer_model.sv ***
// Far-side stand-in: link state and the mirrored pin 3 value.
// Assumes the bench commands it on aclk edges.
`timescale 1ns/1ps
`default_nettype none
module remote_deserializer_model (
    input wire logic aclk,
    input wire logic link_cmd,
    input wire logic value_cmd,
    output var logic link_up,
    output var logic remote_value
);
    initial begin
        link_up = 1'b1;
        remote_value = 1'b0;
    end
    // No link means no valid value, so it keeps moving
    always @(posedge aclk) begin
        link_up <= link_cmd;
        remote_value <= link_cmd ? value_cmd : ~remote_value;
    end
endmodule // remote_deserializer_model
`default_nettype wire

// *** sim/serializer_gpio_config_bank_properties.sv ***
// Bus and pin-state checks on the bank's ports.
// Assumes it is bound to the bank and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module serializer_gpio_config_bank_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pin_three_oe,
    input wire logic second_port_pin_three_oe,
    input wire logic [3:0] pair_pin_oe,
    input wire logic [4:0] gp_input_level,
    input wire logic [4:0] functional_input_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready during response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_one_port: assert property (!(pin_three_oe && second_port_pin_three_oe))
        else $error("both pin 3 ports driven");
    a_func_pin3: assert property (functional_input_active[0] [*3] |-> !pin_three_oe && !second_port_pin_three_oe)
        else $error("pin 3 driven in functional mode");
    a_pair_func: assert property ((functional_input_active[4:1] & $past(functional_input_active[4:1], 3)
        & pair_pin_oe) == 4'h0) else $error("pair pin driven in functional mode");
    a_input_quiet: assert property ((gp_input_level[4:1] & $past(gp_input_level[4:1], 3) & pair_pin_oe) == 4'h0)
        else $error("pair pin driven in input mode");
endmodule // serializer_gpio_config_bank_properties
`default_nettype wire

// *** sim/serializer_gpio_config_bank_tb.sv ***
// Self-checking bench for the pin configuration bank.
// Assumes the remote model supplies link state and pin 3 value.
`timescale 1ns/1ps
`default_nettype none
module serializer_gpio_config_bank_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb = 4'h1, pair_pin_in = 4'ha, pair_pin_out, pair_pin_oe;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic link_up_async, remote_pin_three_async, link_cmd = 1'b1, value_cmd = 1'b0;
    logic pin_three_in = 1'b1, second_port_pin_three_in = 1'b1;
    logic pin_three_out, pin_three_oe, second_port_pin_three_out, second_port_pin_three_oe;
    logic [4:0] gp_input_level, functional_input_active;
    int fails = 0;
    int checked = 0;
    always #20 aclk = ~aclk;
    serializer_gpio_config_bank DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .link_up_async(link_up_async), .remote_pin_three_async(remote_pin_three_async),
        .pin_three_in(pin_three_in), .second_port_pin_three_in(second_port_pin_three_in), .pair_pin_in(pair_pin_in),
        .pin_three_out(pin_three_out), .pin_three_oe(pin_three_oe),
        .second_port_pin_three_out(second_port_pin_three_out), .second_port_pin_three_oe(second_port_pin_three_oe),
        .pair_pin_out(pair_pin_out), .pair_pin_oe(pair_pin_oe),
        .gp_input_level(gp_input_level), .functional_input_active(functional_input_active));
    remote_deserializer_model partner (.aclk(aclk), .link_cmd(link_cmd), .value_cmd(value_cmd),
        .link_up(link_up_async), .remote_value(remote_pin_three_async));
    task settle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task t_reset;
        for (int i = 0; i < 3; i++) begin
            rd(8'(8'h3c + 4 * i));
            chk("reset value", 32'h0, rd_data);
        end
        chk("reset pins", {5'h1f, 6'h0}, {functional_input_active, pin_three_oe, pair_pin_oe,
            second_port_pin_three_oe});
    endtask
    // Local value 1, remote 0: output level tells which source is used
    task t_pin3;
        for (int m = 0; m < 8; m++) begin
            wr(8'h3c, {5'h01, m[2:0]});
            settle(6);
            chk("pin3 mode", {m[0] && m != 3, m == 1, m == 3, m[1:0] == 2'b00}, {pin_three_oe,
                pin_three_oe & pin_three_out, gp_input_level[0], functional_input_active[0]});
        end
    endtask
    task t_loss;
        value_cmd <= 1'b1;
        wr(8'h3c, 8'h07);
        settle(6);
        chk("remote level", 1, pin_three_out);
        link_cmd <= 1'b0;
        settle(8);
        chk("default on loss", 0, pin_three_out);
        wr(8'h3c, 8'h05);
        settle(6);
        chk("hold on loss", 1, pin_three_out);
        link_cmd <= 1'b1;
        value_cmd <= 1'b0;
        settle(6);
        chk("hold follows", 0, pin_three_out);
    endtask
    task t_port;
        second_port_pin_three_in <= 1'b0;
        wr(8'h50, 8'h01);
        wr(8'h3c, 8'h03);
        settle(6);
        chk("second port input", 0, gp_input_level[0]);
        wr(8'h3c, 8'h09);
        settle(6);
        chk("second port", 3'b110, {second_port_pin_three_oe, second_port_pin_three_out, pin_three_oe});
        wr(8'h50, 8'h00);
        settle(6);
        chk("first port", 3'b011, {second_port_pin_three_oe, pin_three_oe, pin_three_out});
    endtask
    // Reserved bits written high must not disturb the pins
    task t_pairs;
        for (int m = 0; m < 4; m++) begin
            wr(8'h40, {2'b11, m[1:0], 2'b11, m[1:0]});
            wr(8'h44, {2'b11, m[1:0], 2'b11, m[1:0]});
            settle(6);
            chk("pair mode", {{4{m == 1}}, {4{m == 1}}, (m == 3) ? 4'ha : 4'h0, {4{m == 0}}}, {pair_pin_oe,
                pair_pin_oe & pair_pin_out, gp_input_level[4:1], functional_input_active[4:1]});
        end
        wr(8'h44, 8'h91);
        wr(8'h40, 8'h00);
        settle(6);
        chk("pin7 pin8", 8'hc8, {pair_pin_oe, pair_pin_oe & pair_pin_out});
    endtask
    task t_reserved;
        wr(8'h3c, 8'hff);
        chk("mapped write resp", 2'b00, wr_resp);
        rd(8'h3c);
        chk("pin3 readback", 32'h0f, rd_data);
        wr(8'h40, 8'hff);
        rd(8'h40);
        chk("pair readback", 32'hbb, rd_data);
        rd(8'h48);
        chk("unmapped resp", 2'b10, rd_resp);
        chk("unmapped data", 32'h0, rd_data);
        wr(8'h48, 8'hff);
        chk("unmapped write resp", 2'b10, wr_resp);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_pin3;
        t_loss;
        t_port;
        t_pairs;
        t_reserved;
        stop_test;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        stop_test;
    end
endmodule // serializer_gpio_config_bank_tb
bind serializer_gpio_config_bank serializer_gpio_config_bank_properties checker_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_three_oe(pin_three_oe), .second_port_pin_three_oe(second_port_pin_three_oe),
    .pair_pin_oe(pair_pin_oe), .gp_input_level(gp_input_level),
    .functional_input_active(functional_input_active));
`default_nettype wire
